/* File: can_mode_defs.svh */
`ifndef CAN_MODE_DEFS_SVH
`define CAN_MODE_DEFS_SVH

// Register indices on the local port
`define ADDR_CONTROL_ONE  4'h0
`define ADDR_CONFIG_TWO   4'h1
`define ADDR_TX_FLAGS     4'h2
`define ADDR_STATUS       4'h3
`define ADDR_BIT_TIMING   4'h4

// Field positions in can_control_one
`define POS_STOP_IN_IDLE  13
`define POS_ABORT_ALL     12
`define POS_REQ_HI        10
`define POS_REQ_LO        8
`define POS_REP_HI        7
`define POS_REP_LO        5
`define POS_CAPTURE_EN    3
`define POS_WINDOW_SEL    0
// Field position in can_config_two
`define POS_WAKE_FILTER   14

// Mode codes, shared by request and reported fields
`define MODE_NORMAL       3'h0
`define MODE_DISABLE      3'h1
`define MODE_LOOPBACK     3'h2
`define MODE_LISTEN_ONLY  3'h3
`define MODE_CONFIG       3'h4
`define MODE_RSVD_A       3'h5
`define MODE_RSVD_B       3'h6
`define MODE_LISTEN_ALL   3'h7

// Reset values
`define RESET_MODE        3'h4
`define RESET_TIMING      16'h0000

// Sizes and timing
`define TX_BUFS           8
`define RX_BUFS           32
`define IDLE_BITS         4'hB
`define MAX_OVERLOAD      2'h2
`define CLK_PERIOD_NS     40
`define WAKE_FILTER_NS    200
`define WAKE_FILTER_CYC   (`WAKE_FILTER_NS / `CLK_PERIOD_NS)

`endif

/* File: can_mode_pkg.sv */
package can_mode_pkg;

  typedef logic [2:0] mode_t;

  typedef struct packed {
    logic [3:0] bits;
  } idle_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic       level;
  } filt_s;

  typedef struct packed {
    logic        stop_in_idle;
    logic        abort_all_tx;
    mode_t       mode_request;
    mode_t       mode_reported;
    logic        rx_capture_enable;
    logic        register_window_select;
    logic        wake_filter_enable;
    logic [15:0] timing_cfg;
    logic [7:0]  tx_request_flag;
    logic [7:0]  tx_aborted_flag;
    logic        wake_int_flag;
    logic        tx_hold;
    logic [1:0]  ovl_cnt;
    logic        capture_event;
    logic        overload_go;
    logic        rx_prev;
    logic        rx_s1;
    logic        rx_s2;
    logic [15:0] rdata;
  } ctl_s;

endpackage

/* File: bus_idle_detect.sv */
`timescale 1ns/100ps
`include "can_mode_defs.svh"

module bus_idle_detect (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic bit_tick,
  input  wire logic rx_level,
  input  wire logic restart,
  output logic      idle
);

  can_mode_pkg::idle_s s;
  can_mode_pkg::idle_s next_s;

  // Count recessive bits, saturating; a dominant bit starts over
  always_comb begin
    next_s = s;
    if (restart || (bit_tick && !rx_level)) begin
      next_s.bits = 4'h0;
    end else if (bit_tick && s.bits != `IDLE_BITS) begin
      next_s.bits = s.bits + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign idle = (s.bits == `IDLE_BITS);

endmodule

/* File: wake_filter.sv */
`timescale 1ns/100ps
`include "can_mode_defs.svh"

module wake_filter (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic rx_level,
  output logic      rx_filt
);

  localparam logic [3:0] FILT_CYC = 4'(`WAKE_FILTER_CYC);

  can_mode_pkg::filt_s s;
  can_mode_pkg::filt_s next_s;

  // Low-pass: a new level is taken only after it held FILT_CYC cycles
  always_comb begin
    next_s = s;
    if (!enable || rx_level == s.level) begin
      next_s.cnt   = 4'h0;
      next_s.level = rx_level;
    end else if (s.cnt == FILT_CYC - 4'h1) begin
      next_s.cnt   = 4'h0;
      next_s.level = rx_level;
    end else begin
      next_s.cnt = s.cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{cnt: 4'h0, level: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign rx_filt = s.level;

endmodule

/* File: can_mode_control.sv */
`timescale 1ns/100ps
`include "can_mode_defs.svh"

module can_mode_control (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        bus_rx_pin,
  output logic             bus_tx_pin_out,
  output logic             bus_tx_pin_oe,
  output logic             rx_pin_owned,
  input  wire logic        bit_tick,
  input  wire logic        engine_tx,
  output logic             engine_rx,
  input  wire logic        tx_busy,
  input  wire logic [7:0]  tx_done,
  output logic      [7:0]  tx_grant,
  input  wire logic        rx_done,
  input  wire logic        overload_req,
  input  wire logic        frame_start,
  output logic             overload_go,
  output logic             capture_event,
  output logic             err_cnt_clear,
  output logic             err_cnt_enable,
  output logic             ack_enable,
  output logic             ignore_errors,
  output logic             rx_enable,
  output logic             module_halt,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  output logic             register_window_select,
  output logic      [15:0] timing_cfg,
  output logic      [5:0]  rx_buf_count
);

  can_mode_pkg::ctl_s s;
  can_mode_pkg::ctl_s next_s;

  logic  bus_idle;
  logic  rx_filt;
  logic  idle_restart;
  logic  in_config;
  logic  tx_mode;
  logic  wr_ctrl;
  logic  wr_req_ok;
  can_mode_pkg::mode_t req;
  can_mode_pkg::mode_t wr_req;

  assign req       = s.mode_request;
  assign in_config = (s.mode_reported == `MODE_CONFIG);
  assign tx_mode   = (s.mode_reported == `MODE_NORMAL) ||
                     (s.mode_reported == `MODE_LOOPBACK);
  assign wr_ctrl   = reg_wr && reg_addr == `ADDR_CONTROL_ONE;
  assign wr_req    = reg_wdata[`POS_REQ_HI:`POS_REQ_LO];
  // Reserved codes are dropped so the request never holds them
  assign wr_req_ok = wr_req != `MODE_RSVD_A &&
                     wr_req != `MODE_RSVD_B;

  // Restart the idle count on a mode change so the startup hold
  // sees eleven fresh recessive bits
  assign idle_restart = (next_s.mode_reported != s.mode_reported);

  bus_idle_detect u_idle (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bit_tick (bit_tick),
    .rx_level (s.rx_s2),
    .restart  (idle_restart),
    .idle     (bus_idle)
  );

  // Filter is only in the path while asleep, as the wake source
  wake_filter u_wake (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (s.wake_filter_enable && cpu_sleep),
    .rx_level (s.rx_s2),
    .rx_filt  (rx_filt)
  );

  // Main state update: synchroniser, mode, flags, registers
  always_comb begin
    next_s       = s;
    next_s.rx_s1 = bus_rx_pin;
    next_s.rx_s2 = s.rx_s1;
    next_s.rx_prev = rx_filt;

    // Mode switch waits for idle; config also waits for tx end
    if (req != s.mode_reported && bus_idle &&
        !(req == `MODE_CONFIG && tx_busy)) begin
      next_s.mode_reported = req;
    end
    if ((req == `MODE_NORMAL || req == `MODE_LOOPBACK) &&
        next_s.mode_reported == req &&
        s.mode_reported != req) begin
      next_s.tx_hold = 1'b1;
    end else if (bus_idle) begin
      next_s.tx_hold = 1'b0;
    end

    // Engine completions clear request flags
    next_s.tx_request_flag = s.tx_request_flag & ~tx_done;

    // Abort-all: flag every pending buffer, drop its request
    if (s.abort_all_tx) begin
      next_s.tx_aborted_flag = s.tx_aborted_flag |
                               s.tx_request_flag;
      next_s.tx_request_flag = 8'h00;
      if (!tx_busy) begin
        next_s.abort_all_tx = 1'b0;
      end
    end

    // Wake on bus activity in disable mode; pending flags stay
    if (reg_wr && reg_addr == `ADDR_STATUS && reg_wdata[0]) begin
      next_s.wake_int_flag = 1'b0;
    end
    if (s.mode_reported == `MODE_DISABLE && s.rx_prev &&
        !rx_filt) begin
      next_s.wake_int_flag = 1'b1;
    end

    // Overload frames: at most two back to back per frame gap
    next_s.overload_go = 1'b0;
    if (frame_start) begin
      next_s.ovl_cnt = 2'h0;
    end else if (overload_req && s.ovl_cnt < `MAX_OVERLOAD) begin
      next_s.ovl_cnt     = s.ovl_cnt + 2'h1;
      next_s.overload_go = 1'b1;
    end

    // One capture pulse per received message when enabled
    next_s.capture_event = rx_done && s.rx_capture_enable &&
                           rx_enable;

    // Register writes
    if (wr_ctrl) begin
      if (wr_req_ok) begin
        next_s.mode_request = wr_req;
      end
      if (reg_wdata[`POS_ABORT_ALL]) begin
        next_s.abort_all_tx = 1'b1;
      end
      // Early disable while transmissions are held aborts them
      if (wr_req_ok && wr_req == `MODE_DISABLE && s.tx_hold) begin
        next_s.tx_aborted_flag = s.tx_aborted_flag |
                                 s.tx_request_flag;
        next_s.tx_request_flag = 8'h00;
      end
      if (in_config) begin
        next_s.stop_in_idle = reg_wdata[`POS_STOP_IN_IDLE];
        next_s.rx_capture_enable =
          reg_wdata[`POS_CAPTURE_EN];
        next_s.register_window_select =
          reg_wdata[`POS_WINDOW_SEL];
      end
    end
    if (reg_wr && in_config) begin
      if (reg_addr == `ADDR_CONFIG_TWO) begin
        next_s.wake_filter_enable =
          reg_wdata[`POS_WAKE_FILTER];
      end
      if (reg_addr == `ADDR_BIT_TIMING) begin
        next_s.timing_cfg = reg_wdata;
      end
    end
    if (reg_wr && reg_addr == `ADDR_TX_FLAGS) begin
      // Aborted flags clear by writing one; new aborts win
      next_s.tx_aborted_flag = next_s.tx_aborted_flag &
                               ~reg_wdata[15:8] |
                               (next_s.tx_aborted_flag &
                                ~s.tx_aborted_flag);
      if (!s.abort_all_tx) begin
        next_s.tx_request_flag = next_s.tx_request_flag |
                                 reg_wdata[7:0];
      end
    end

    // Read data stands only in the cycle after the strobe
    next_s.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_CONTROL_ONE: begin
          next_s.rdata[`POS_STOP_IN_IDLE] = s.stop_in_idle;
          next_s.rdata[`POS_ABORT_ALL]    = s.abort_all_tx;
          next_s.rdata[`POS_REQ_HI:`POS_REQ_LO] = s.mode_request;
          next_s.rdata[`POS_REP_HI:`POS_REP_LO] =
            s.mode_reported;
          next_s.rdata[`POS_CAPTURE_EN] = s.rx_capture_enable;
          next_s.rdata[`POS_WINDOW_SEL] = s.register_window_select;
        end
        `ADDR_CONFIG_TWO: begin
          next_s.rdata[`POS_WAKE_FILTER] = s.wake_filter_enable;
        end
        `ADDR_TX_FLAGS: begin
          next_s.rdata = {s.tx_aborted_flag, s.tx_request_flag};
        end
        `ADDR_STATUS: begin
          next_s.rdata[2:0] = {s.tx_hold, bus_idle,
                               s.wake_int_flag};
        end
        `ADDR_BIT_TIMING: begin
          next_s.rdata = s.timing_cfg;
        end
        default: begin
          next_s.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mode_request  <= `RESET_MODE;
      s.mode_reported <= `RESET_MODE;
      s.timing_cfg    <= `RESET_TIMING;
      s.rx_prev       <= 1'b1;
      s.rx_s1         <= 1'b1;
      s.rx_s2         <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Mode decode for the protocol engine and the pins
  always_comb begin
    rx_enable      = 1'b0;
    ack_enable     = 1'b0;
    err_cnt_enable = 1'b0;
    ignore_errors  = 1'b0;
    bus_tx_pin_oe  = 1'b0;
    unique case (s.mode_reported)
      `MODE_NORMAL: begin
        rx_enable      = 1'b1;
        ack_enable     = 1'b1;
        err_cnt_enable = 1'b1;
        bus_tx_pin_oe  = 1'b1;
      end
      `MODE_LISTEN_ONLY: begin
        rx_enable = 1'b1;
      end
      `MODE_LISTEN_ALL: begin
        rx_enable     = 1'b1;
        ignore_errors = 1'b1;
      end
      `MODE_LOOPBACK: begin
        rx_enable      = 1'b1;
        ack_enable     = 1'b1;
        err_cnt_enable = 1'b1;
      end
      default: begin
        rx_enable = 1'b0;
      end
    endcase
  end

  assign err_cnt_clear  = in_config;
  assign module_halt    = s.stop_in_idle && cpu_idle;
  assign rx_pin_owned   = rx_enable &&
                          s.mode_reported != `MODE_LOOPBACK;
  assign bus_tx_pin_out = engine_tx | ~bus_tx_pin_oe;
  // Loopback closes transmit onto receive inside the boundary
  assign engine_rx = (s.mode_reported == `MODE_LOOPBACK) ?
                     engine_tx : (rx_pin_owned ? s.rx_s2 : 1'b1);
  // Requests only leave once the startup hold has expired
  assign tx_grant = (tx_mode && !s.tx_hold && !s.abort_all_tx &&
                     !module_halt) ? s.tx_request_flag : 8'h00;
  assign rx_buf_count = 6'(`RX_BUFS);
  assign overload_go  = s.overload_go;
  assign capture_event = s.capture_event;
  assign register_window_select = s.register_window_select;
  assign timing_cfg = s.timing_cfg;
  assign reg_rdata  = s.rdata;

  // Checks
  mode_waits_idle_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) $changed(s.mode_reported) |->
    $past(bus_idle)) else $error("mode changed off idle");
  mode_follows_req_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) $changed(s.mode_reported) |->
    s.mode_reported == $past(s.mode_request))
    else $error("mode not the requested one");
  cfg_after_tx_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) $changed(s.mode_reported) &&
    s.mode_reported == `MODE_CONFIG |-> !$past(tx_busy))
    else $error("config entered during transmission");
  no_reserved_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) s.mode_request != `MODE_RSVD_A &&
    s.mode_request != `MODE_RSVD_B)
    else $error("reserved mode request held");
  cfg_quiet_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) in_config |-> !rx_enable &&
    !bus_tx_pin_oe && tx_grant == 8'h00 && err_cnt_clear)
    else $error("config mode not quiet");
  disable_free_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) s.mode_reported == `MODE_DISABLE |->
    !bus_tx_pin_oe && !rx_pin_owned)
    else $error("disable mode holds pins");
  lock_timing_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) !in_config |=> $stable(s.timing_cfg))
    else $error("timing written on-line");
  hold_blocks_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) s.tx_hold |-> tx_grant == 8'h00)
    else $error("grant during startup hold");
  abort_clears_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) s.abort_all_tx |=>
    s.tx_request_flag == 8'h00)
    else $error("request survived abort-all");
  overload_two_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) s.ovl_cnt <= `MAX_OVERLOAD)
    else $error("too many overload frames");
  listen_only_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) s.mode_reported == `MODE_LISTEN_ONLY |->
    !ack_enable && !err_cnt_enable && !bus_tx_pin_oe)
    else $error("listen-only not passive");
  halt_idle_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) module_halt == (s.stop_in_idle && cpu_idle))
    else $error("halt wrong");

  enter_normal_c: cover property (@(posedge core_clk)
    disable iff (!rst_n) $changed(s.mode_reported) &&
    s.mode_reported == `MODE_NORMAL);
  early_abort_c: cover property (@(posedge core_clk)
    disable iff (!rst_n) s.tx_hold && wr_ctrl &&
    wr_req == `MODE_DISABLE && s.tx_request_flag != 8'h00);
  wake_c: cover property (@(posedge core_clk)
    disable iff (!rst_n) $rose(s.wake_int_flag));

endmodule

/* File: can_bus_node.sv */
`timescale 1ns/100ps

// Far-side bus node behind the transceiver: wired-AND of all drivers
module can_bus_node (
  input  wire logic tx_out,
  input  wire logic tx_oe,
  input  wire logic pull_dom,
  output logic      rx
);
  // A released pin leaves the bus recessive by the transceiver pull
  assign rx = (tx_oe ? tx_out : 1'b1) & ~pull_dom;
endmodule

/* File: can_mode_control_test.sv */
`timescale 1ns/100ps
`include "can_mode_defs.svh"

module can_mode_control_test;
  localparam logic [15:0] ctl_keep = 16'h2009;
  logic        core_clk, rst_n, reg_wr, reg_rd, bit_tick, engine_tx;
  logic        tx_busy, rx_done, overload_req, frame_start, cpu_idle;
  logic        cpu_sleep, pull_dom, bus_rx_pin, bus_tx_pin_out;
  logic        bus_tx_pin_oe, rx_pin_owned, engine_rx, overload_go;
  logic        capture_event, err_cnt_clear, err_cnt_enable, ack_enable;
  logic        ignore_errors, rx_enable, module_halt;
  logic        register_window_select;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, timing_cfg, rv;
  logic [7:0]  tx_done, tx_grant;
  logic [5:0]  rx_buf_count;
  int          errors, n_compared;

  can_mode_control uut (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bus_rx_pin, .bus_tx_pin_out, .bus_tx_pin_oe,
    .rx_pin_owned, .bit_tick, .engine_tx, .engine_rx, .tx_busy,
    .tx_done, .tx_grant, .rx_done, .overload_req, .frame_start,
    .overload_go, .capture_event, .err_cnt_clear, .err_cnt_enable,
    .ack_enable, .ignore_errors, .rx_enable, .module_halt, .cpu_idle,
    .cpu_sleep, .register_window_select, .timing_cfg, .rx_buf_count
  );

  can_bus_node bus (
    .tx_out   (bus_tx_pin_out),
    .tx_oe    (bus_tx_pin_oe),
    .pull_dom (pull_dom),
    .rx       (bus_rx_pin)
  );

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle strobes; a gap edge between calls avoids double drives
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rv = reg_rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      bit_tick <= 1'b1;
      @(posedge core_clk);
      bit_tick <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask

  // Expected {oe, owned, ack, err count, ignore, rx enable} per mode
  function automatic logic [5:0] outs_for(input logic [2:0] m);
    case (m)
      `MODE_NORMAL:      return 6'h3D;
      `MODE_LOOPBACK:    return 6'h0D;
      `MODE_LISTEN_ONLY: return 6'h11;
      `MODE_LISTEN_ALL:  return 6'h13;
      default:           return 6'h00;
    endcase
  endfunction

  task automatic check_outs(input logic [2:0] m);
    chk("mode outputs", {bus_tx_pin_oe, rx_pin_owned, ack_enable,
        err_cnt_enable, ignore_errors, rx_enable},
        outs_for(m));
    chk("counter clear", err_cnt_clear, m == `MODE_CONFIG);
  endtask

  // A dominant tick first, so the idle count restarts from zero
  task automatic set_mode(input logic [2:0] m);
    logic [2:0] old;
    rd_reg(`ADDR_CONTROL_ONE);
    old = rv[7:5];
    @(posedge core_clk);
    pull_dom <= 1'b1;
    repeat (3) @(posedge core_clk);
    ticks(1);
    pull_dom <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr_reg(`ADDR_CONTROL_ONE, ctl_keep | {5'h00, m, 8'h00});
    ticks(10);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("mode before idle", rv[7:5], old);
    ticks(1);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("mode reported", rv[7:5], m);
    check_outs(m);
  endtask

  task automatic test_reset;
    rd_reg(`ADDR_CONTROL_ONE);
    chk("control after reset", rv, 16'h0480);
    check_outs(`MODE_CONFIG);
    chk("tx pin idle", bus_tx_pin_out, 1'b1);
    chk("rx buffers", rx_buf_count, 6'h20);
    chk("grant after reset", tx_grant, 8'h00);
    $display("reset test done");
  endtask

  task automatic test_config_lock;
    wr_reg(`ADDR_CONTROL_ONE, 16'h2409);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("control in config", rv, 16'h2489);
    chk("window select", register_window_select, 1'b1);
    wr_reg(`ADDR_BIT_TIMING, 16'hA5C3);
    rd_reg(`ADDR_BIT_TIMING);
    chk("timing in config", rv, 16'hA5C3);
    chk("timing port", timing_cfg, 16'hA5C3);
    wr_reg(`ADDR_CONFIG_TWO, 16'h4000);
    rd_reg(`ADDR_CONFIG_TWO);
    chk("config two", rv, 16'h4000);
    rd_reg(4'hF);
    chk("unmapped read", rv, 16'h0000);
    @(posedge core_clk);
    cpu_idle <= 1'b1;
    @(negedge core_clk);
    chk("halt in idle", module_halt, 1'b1);
    @(posedge core_clk);
    cpu_idle <= 1'b0;
    @(negedge core_clk);
    chk("run out of idle", module_halt, 1'b0);
    $display("config lock test done");
  endtask

  // Online: locked fields keep; early disable aborts held requests
  task automatic test_early_abort;
    wr_reg(`ADDR_BIT_TIMING, 16'h0000);
    wr_reg(`ADDR_CONTROL_ONE, 16'h0000);
    rd_reg(`ADDR_BIT_TIMING);
    chk("timing online", rv, 16'hA5C3);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("control online", rv, ctl_keep);
    wr_reg(`ADDR_TX_FLAGS, 16'h0005);
    // Look once the flags have settled, so a broken hold would show
    @(negedge core_clk);
    chk("grant held", tx_grant, 8'h00);
    set_mode(`MODE_DISABLE);
    rd_reg(`ADDR_TX_FLAGS);
    chk("early abort flags", rv, 16'h0500);
    $display("early abort test done");
  endtask

  // A short glitch is filtered out, a long dominant level wakes
  task automatic test_wake;
    @(posedge core_clk);
    cpu_sleep <= 1'b1;
    pull_dom <= 1'b1;
    repeat (2) @(posedge core_clk);
    pull_dom <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd_reg(`ADDR_STATUS);
    chk("wake on glitch", rv[0], 1'b0);
    @(posedge core_clk);
    pull_dom <= 1'b1;
    repeat (10) @(posedge core_clk);
    pull_dom <= 1'b0;
    @(negedge core_clk);
    chk("rx released", engine_rx, 1'b1);
    repeat (3) @(posedge core_clk);
    rd_reg(`ADDR_STATUS);
    chk("wake flag", rv[0], 1'b1);
    @(posedge core_clk);
    cpu_sleep <= 1'b0;
    wr_reg(`ADDR_STATUS, 16'h0001);
    rd_reg(`ADDR_STATUS);
    chk("wake cleared", rv[0], 1'b0);
    $display("wake test done");
  endtask

  task automatic test_tx_abort_all;
    wr_reg(`ADDR_TX_FLAGS, 16'h0003);
    @(negedge core_clk);
    chk("grant", tx_grant, 8'h03);
    @(posedge core_clk);
    tx_done <= 8'h01;
    @(posedge core_clk);
    tx_done <= 8'h00;
    rd_reg(`ADDR_TX_FLAGS);
    chk("flags after done", rv, 16'h0502);
    @(posedge core_clk);
    tx_busy <= 1'b1;
    wr_reg(`ADDR_CONTROL_ONE, 16'h1000);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("abort pending", rv, 16'h3009);
    rd_reg(`ADDR_TX_FLAGS);
    chk("flags after abort", rv, 16'h0700);
    @(posedge core_clk);
    tx_busy <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("abort self clear", rv, ctl_keep);
    $display("abort all test done");
  endtask

  task automatic test_capture_overload;
    int n;
    n = 0;
    @(posedge core_clk);
    rx_done <= 1'b1;
    @(posedge core_clk);
    rx_done <= 1'b0;
    @(negedge core_clk);
    chk("capture pulse", capture_event, 1'b1);
    @(negedge core_clk);
    chk("capture one cycle", capture_event, 1'b0);
    repeat (3) begin
      @(posedge core_clk);
      overload_req <= 1'b1;
      @(posedge core_clk);
      overload_req <= 1'b0;
      @(negedge core_clk);
      n += overload_go;
    end
    chk("overload count", n[15:0], 16'h0002);
    @(posedge core_clk);
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    overload_req <= 1'b1;
    @(posedge core_clk);
    overload_req <= 1'b0;
    @(negedge core_clk);
    chk("overload after frame", overload_go, 1'b1);
    $display("capture and overload test done");
  endtask

  task automatic test_modes;
    set_mode(`MODE_LOOPBACK);
    @(posedge core_clk);
    engine_tx <= 1'b0;
    @(negedge core_clk);
    chk("loopback rx", engine_rx, 1'b0);
    @(posedge core_clk);
    engine_tx <= 1'b1;
    set_mode(`MODE_LISTEN_ONLY);
    set_mode(`MODE_LISTEN_ALL);
    wr_reg(`ADDR_CONTROL_ONE, ctl_keep | 16'h0500);
    wr_reg(`ADDR_CONTROL_ONE, ctl_keep | 16'h0600);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("reserved request", rv[10:8], `MODE_LISTEN_ALL);
    $display("mode table test done");
  endtask

  // Configuration entry is deferred while a frame is on the wire
  task automatic test_config_defer;
    @(posedge core_clk);
    tx_busy <= 1'b1;
    wr_reg(`ADDR_CONTROL_ONE, ctl_keep | 16'h0400);
    ticks(12);
    rd_reg(`ADDR_CONTROL_ONE);
    chk("no config while busy", rv[7:5], `MODE_LISTEN_ALL);
    @(posedge core_clk);
    tx_busy <= 1'b0;
    for (int i = 0; i < 8 && rv[7:5] !== `MODE_CONFIG; i++) begin
      rd_reg(`ADDR_CONTROL_ONE);
    end
    chk("config after busy", rv[7:5], `MODE_CONFIG);
    check_outs(`MODE_CONFIG);
    $display("config defer test done");
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    $display("timeout");
    report_and_stop();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, bit_tick, tx_busy, rx_done} = '0;
    {overload_req, frame_start, cpu_idle, cpu_sleep, pull_dom} = '0;
    engine_tx = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    tx_done = 8'h00;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    test_reset();
    test_config_lock();
    set_mode(`MODE_NORMAL);
    test_early_abort();
    test_wake();
    set_mode(`MODE_NORMAL);
    ticks(12);
    test_tx_abort_all();
    test_capture_overload();
    test_modes();
    test_config_defer();
    report_and_stop();
  end
endmodule
